// ==== logic/rtpb_pkg.sv ====
/*
  Constants for the restart and thermal parameter bank: register offsets,
  index table with legal ranges and reset values, codes, status layout
  and timing. Assumes a 100 MHz core clock.
*/
`default_nettype none

package rtpb_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_REGS = 12;

  // Bank indices, in table order
  localparam logic [3:0] IDX_METHOD   = 4'h0;
  localparam logic [3:0] IDX_UV_TIME  = 4'h1;
  localparam logic [3:0] IDX_RETRY    = 4'h2;
  localparam logic [3:0] IDX_ALARM_EN = 4'h3;
  localparam logic [3:0] IDX_CNT_SEL  = 4'h4;
  localparam logic [3:0] IDX_THERM    = 4'h5;
  localparam logic [3:0] IDX_CURVE    = 4'h6;
  localparam logic [3:0] IDX_OLMODE   = 4'h7;
  localparam logic [3:0] IDX_PULLIN   = 4'h8;
  localparam logic [3:0] IDX_THERM2   = 4'h9;
  localparam logic [3:0] IDX_CURVE2   = 4'hA;
  localparam logic [3:0] IDX_OLMODE2  = 4'hB;
  localparam logic [3:0] IDX_NONE     = 4'hF;

  // Word offsets of the holding registers
  localparam logic [15:0] REG_OFS [NUM_REGS] = '{
    16'h10A5, 16'h10A6, 16'h10A7, 16'h10A8, 16'h10A9, 16'h10AD,
    16'h10AE, 16'h10B5, 16'h1170, 16'h1527, 16'h1528, 16'h1529};
  // Legal write range per register; others are refused
  localparam logic [15:0] REG_MIN [NUM_REGS] = '{
    16'h0000, 16'h0003, 16'h0003, 16'h0000, 16'h0000, 16'h07D0,
    16'h0000, 16'h0000, 16'h0000, 16'h07D0, 16'h0000, 16'h0000};
  localparam logic [15:0] REG_MAX [NUM_REGS] = '{
    16'h0003, 16'h00FA, 16'h03E8, 16'h0001, 16'h0001, 16'h2710,
    16'h0002, 16'h0002, 16'h0002, 16'h2710, 16'h0002, 16'h0002};
  localparam logic [15:0] REG_RST [NUM_REGS] = '{
    16'h0000, 16'h000A, 16'h000A, 16'h0000, 16'h0000, 16'h2710,
    16'h0001, 16'h0001, 16'h0000, 16'h2710, 16'h0001, 16'h0001};

  // Status and control word
  localparam logic [15:0] OFS_STATUS = 16'h1600;
  localparam int unsigned STAT_TRIP_BIT  = 0;
  localparam int unsigned STAT_CAUSE_LSB = 1;
  localparam int unsigned STAT_CNT_LSB   = 3;
  localparam int unsigned STAT_REJ_BIT   = 8;

  // Restart method codes
  localparam logic [1:0] METH_ALARM      = 2'h0;
  localparam logic [1:0] METH_ZERO       = 2'h1;
  localparam logic [1:0] METH_MATCH      = 2'h2;
  localparam logic [1:0] METH_MATCH_STOP = 2'h3;

  // Restart count and alarm enable codes
  localparam logic CNT_LIMITED = 1'b0;
  localparam logic ALARM_ON    = 1'b1;
  localparam logic [4:0] RESTART_LIMIT = 5'h10;

  // Trip causes
  localparam logic [1:0] CAUSE_NONE  = 2'h0;
  localparam logic [1:0] CAUSE_UV    = 2'h1;
  localparam logic [1:0] CAUSE_FAULT = 2'h2;
  localparam logic [1:0] CAUSE_LIMIT = 2'h3;

  // Timing: one count step of the time registers
  localparam int unsigned TENTH_SEC_NS = 100000000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TENTH_SEC_CYCLES = TENTH_SEC_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_RUN, ST_UV, ST_RETRY, ST_ZERO, ST_MATCH, ST_DECEL, ST_TRIP
  } rtpb_state_e;

endpackage : rtpb_pkg

`default_nettype wire

// ==== logic/rtpb_sync.sv ====
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes the pins are slow levels, never multi-bit words.
*/
`timescale 1ns/1ps
`default_nettype none

module rtpb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      meta_q <= pin_i;
      sync_o <= meta_q;
    end
  end

endmodule : rtpb_sync

`default_nettype wire

// ==== logic/rtpb_tick.sv ====
/*
  Prescaler giving one pulse per tenth of a second.
  Assumes CYCLES of at least two; clr_i restarts the phase.
*/
`timescale 1ns/1ps
`default_nettype none

module rtpb_tick #(
  parameter int unsigned CYCLES = 10
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic clr_i,
  output logic      tick_o
);

  localparam int unsigned CW = $clog2(CYCLES);

  logic [CW-1:0] cnt_q;

  // Phase restarts on clear so each timed wait is whole
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (clr_i) begin
        cnt_q  <= '0;
        tick_o <= 1'b0;
      end else if (cnt_q == CW'(CYCLES - 1)) begin
        cnt_q  <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_q  <= CW'(cnt_q + 1'b1);
        tick_o <= 1'b0;
      end
    end
  end

endmodule : rtpb_tick

`default_nettype wire

// ==== logic/rtpb_bank.sv ====
/*
  Restart and thermal parameter bank: holding registers, restart
  sequencer and active thermal selection for motor one or two.
  Assumes a plain register port on the core clock, asynchronous pins
  for under-voltage, fault and motor select, and a drive core on the
  same clock answering the match and stop handshakes.
*/
// Design decision made here: the address-and-strobe port.
// Contract
// - Method codes: alarm, zero start, match resume
// - Under-voltage beyond allowed time always trips; the sequencer ignores uv_s in ST_MATCH and ST_DECEL
// - Wait retry time after under-voltage clears
// - Count code zero limits restarts to sixteen
// - Pull-in start frequency chosen by code
// - Thermal level held between 2000 and 10000
// - Thermal curve selects one of three
// - Overload mode: off, accel+constant, constant only
`timescale 1ns/1ps
`default_nettype none

module rtpb_bank #(
  parameter int unsigned TENTH_CYCLES = rtpb_pkg::TENTH_SEC_CYCLES
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // Asynchronous pins
  input  wire logic        uv_pin_i,
  input  wire logic        fault_pin_i,
  input  wire logic        motor2_pin_i,
  // Drive core handshakes
  input  wire logic        match_done_i,
  input  wire logic        stop_done_i,
  output logic             run_enable_o,
  output logic             restart_zero_o,
  output logic             match_req_o,
  output logic      [1:0]  match_freq_sel_o,
  output logic             decel_stop_o,
  output logic             trip_o,
  output logic             alarm_o,
  output logic      [1:0]  trip_cause_o,
  // Active thermal and overload settings
  output logic      [15:0] thermal_level_o,
  output logic      [1:0]  thermal_curve_o,
  output logic      [1:0]  overload_mode_o
);

  logic [15:0]           bank_q [rtpb_pkg::NUM_REGS];
  logic [2:0]            pin_s;
  logic                  uv_s;
  logic                  fault_s;
  logic                  motor2_s;
  logic                  fault_d1_q;
  logic                  fault_rise;
  logic                  tick;
  logic                  timer_clr;
  logic [15:0]           elapsed_q;
  logic [4:0]            restarts_q;
  logic [1:0]            event_cause_q;
  logic [1:0]            trip_cause_q;
  logic                  reject_q;
  logic [15:0]           rdata_q;
  logic [15:0]           status;
  logic [3:0]            wr_idx;
  logic [3:0]            rd_idx;
  logic                  stat_wr;
  logic                  clr_trip;
  logic                  limit_hit;
  logic                  retry_done;
  logic                  uv_expired;
  logic [1:0]            method;
  rtpb_pkg::rtpb_state_e state_q;
  rtpb_pkg::rtpb_state_e state_d;

  // Offset to bank index; IDX_NONE when unmapped
  function automatic logic [3:0] find_reg(input logic [15:0] a);
    logic [3:0] idx;
    idx = rtpb_pkg::IDX_NONE;
    for (int i = 0; i < rtpb_pkg::NUM_REGS; i++) begin
      if (a == rtpb_pkg::REG_OFS[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : find_reg

  // Legal value for the register at idx
  function automatic logic in_range(input logic [3:0] idx,
                                    input logic [15:0] v);
    return (v >= rtpb_pkg::REG_MIN[idx]) && (v <= rtpb_pkg::REG_MAX[idx]);
  endfunction : in_range

  // Pins cross into the core domain before anything reads them
  rtpb_sync #(
    .W (3)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .pin_i      ({motor2_pin_i, fault_pin_i, uv_pin_i}),
    .sync_o     (pin_s)
  );

  assign uv_s     = pin_s[0];
  assign fault_s  = pin_s[1];
  assign motor2_s = pin_s[2];

  // Fault edge taken from the settled copy only
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fault_d1_q <= 1'b0;
    end else if (ce_i) begin
      fault_d1_q <= fault_s;
    end
  end

  assign fault_rise = fault_s & ~fault_d1_q;

  // Tenth-second base, restarted on every state change
  rtpb_tick #(
    .CYCLES (TENTH_CYCLES)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .clr_i      (timer_clr),
    .tick_o     (tick)
  );

  // Decode shared by the bank, the status word and the FSM
  assign wr_idx   = find_reg(addr_i);
  assign rd_idx   = wr_idx;
  assign stat_wr  = wr_i && (addr_i == rtpb_pkg::OFS_STATUS);
  assign clr_trip = stat_wr && wdata_i[rtpb_pkg::STAT_TRIP_BIT];
  assign method   = bank_q[rtpb_pkg::IDX_METHOD][1:0];

  // Holding registers; out-of-range writes leave the old value
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < rtpb_pkg::NUM_REGS; i++) begin
        bank_q[i] <= rtpb_pkg::REG_RST[i];
      end
    end else if (ce_i) begin
      if (wr_i && (wr_idx != rtpb_pkg::IDX_NONE) &&
          in_range(wr_idx, wdata_i)) begin
        bank_q[wr_idx] <= wdata_i;
      end
    end
  end

  // Refused write flag; a new refusal beats a same-cycle clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reject_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_i && (wr_idx != rtpb_pkg::IDX_NONE) &&
          !in_range(wr_idx, wdata_i)) begin
        reject_q <= 1'b1;
      end else if (stat_wr && wdata_i[rtpb_pkg::STAT_REJ_BIT]) begin
        reject_q <= 1'b0;
      end
    end
  end

  // Status word: trip, cause, restart count, refused write
  always_comb begin
    status = '0;
    status[rtpb_pkg::STAT_TRIP_BIT] = (state_q == rtpb_pkg::ST_TRIP);
    status[rtpb_pkg::STAT_CAUSE_LSB +: 2] = trip_cause_q;
    status[rtpb_pkg::STAT_CNT_LSB +: 5] = restarts_q;
    status[rtpb_pkg::STAT_REJ_BIT] = reject_q;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (ce_i) begin
      if (!rd_i) begin
        rdata_q <= '0;
      end else if (rd_idx != rtpb_pkg::IDX_NONE) begin
        rdata_q <= bank_q[rd_idx];
      end else if (addr_i == rtpb_pkg::OFS_STATUS) begin
        rdata_q <= status;
      end else begin
        rdata_q <= '0;
      end
    end
  end

  assign rdata_o = rdata_q;

  // Timed waits; both compare against whole tenths
  assign uv_expired = tick &&
                      (elapsed_q == bank_q[rtpb_pkg::IDX_UV_TIME]);
  assign retry_done = tick && (16'(elapsed_q + 16'h0001) ==
                               bank_q[rtpb_pkg::IDX_RETRY]);
  assign limit_hit  = (bank_q[rtpb_pkg::IDX_CNT_SEL][0] ==
                       rtpb_pkg::CNT_LIMITED) &&
                      (restarts_q == rtpb_pkg::RESTART_LIMIT);

  // Restart sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      rtpb_pkg::ST_RUN: begin
        if (uv_s) begin
          state_d = rtpb_pkg::ST_UV;
        end else if (fault_rise) begin
          if (method == rtpb_pkg::METH_ALARM) begin
            state_d = rtpb_pkg::ST_TRIP;
          end else begin
            state_d = rtpb_pkg::ST_RETRY;
          end
        end
      end
      rtpb_pkg::ST_UV: begin
        if (uv_expired) begin
          state_d = rtpb_pkg::ST_TRIP;
        end else if (!uv_s) begin
          state_d = rtpb_pkg::ST_RETRY;
        end
      end
      rtpb_pkg::ST_RETRY: begin
        if (uv_s) begin
          state_d = rtpb_pkg::ST_UV;
        end else if (retry_done) begin
          if (limit_hit) begin
            state_d = rtpb_pkg::ST_TRIP;
          end else if (method == rtpb_pkg::METH_MATCH ||
                       method == rtpb_pkg::METH_MATCH_STOP) begin
            state_d = rtpb_pkg::ST_MATCH;
          end else begin
            state_d = rtpb_pkg::ST_ZERO;
          end
        end
      end
      rtpb_pkg::ST_ZERO: begin
        state_d = rtpb_pkg::ST_RUN;
      end
      rtpb_pkg::ST_MATCH: begin
        if (match_done_i) begin
          if (method == rtpb_pkg::METH_MATCH_STOP) begin
            state_d = rtpb_pkg::ST_DECEL;
          end else begin
            state_d = rtpb_pkg::ST_RUN;
          end
        end
      end
      rtpb_pkg::ST_DECEL: begin
        if (stop_done_i) begin
          state_d = rtpb_pkg::ST_TRIP;
        end
      end
      rtpb_pkg::ST_TRIP: begin
        if (clr_trip) begin
          state_d = rtpb_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = rtpb_pkg::ST_TRIP;
      end
    endcase
  end

  assign timer_clr = (state_d != state_q);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= rtpb_pkg::ST_RUN;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // Tenths spent in the current timed state
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      elapsed_q <= '0;
    end else if (ce_i) begin
      if (timer_clr) begin
        elapsed_q <= '0;
      end else if (tick) begin
        elapsed_q <= 16'(elapsed_q + 16'h0001);
      end
    end
  end

  // Restarts counted only while the limit applies
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      restarts_q <= '0;
    end else if (ce_i) begin
      if (clr_trip && state_q == rtpb_pkg::ST_TRIP) begin
        restarts_q <= '0;
      end else if (state_q == rtpb_pkg::ST_RETRY && retry_done &&
                   !uv_s && !limit_hit &&
                   bank_q[rtpb_pkg::IDX_CNT_SEL][0] ==
                   rtpb_pkg::CNT_LIMITED) begin
        restarts_q <= 5'(restarts_q + 5'h01);
      end
    end
  end

  // Cause of the event being ridden through
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      event_cause_q <= rtpb_pkg::CAUSE_NONE;
    end else if (ce_i && state_q == rtpb_pkg::ST_RUN) begin
      if (uv_s) begin
        event_cause_q <= rtpb_pkg::CAUSE_UV;
      end else if (fault_rise) begin
        event_cause_q <= rtpb_pkg::CAUSE_FAULT;
      end
    end
  end

  // Trip information kept until software clears the trip
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      trip_cause_q <= rtpb_pkg::CAUSE_NONE;
    end else if (ce_i) begin
      if (state_d == rtpb_pkg::ST_TRIP &&
          state_q != rtpb_pkg::ST_TRIP) begin
        if (state_q == rtpb_pkg::ST_RETRY) begin
          trip_cause_q <= rtpb_pkg::CAUSE_LIMIT;
        end else if (state_q == rtpb_pkg::ST_RUN) begin
          trip_cause_q <= rtpb_pkg::CAUSE_FAULT;
        end else if (state_q == rtpb_pkg::ST_UV) begin
          trip_cause_q <= rtpb_pkg::CAUSE_UV;
        end else begin
          trip_cause_q <= event_cause_q;
        end
      end else if (state_d != rtpb_pkg::ST_TRIP) begin
        trip_cause_q <= rtpb_pkg::CAUSE_NONE;
      end
    end
  end

  // Drive-core handshakes, one cycle behind the sequencer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      run_enable_o     <= 1'b1;
      restart_zero_o   <= 1'b0;
      match_req_o      <= 1'b0;
      match_freq_sel_o <= 2'h0;
      decel_stop_o     <= 1'b0;
    end else if (ce_i) begin
      run_enable_o     <= (state_q == rtpb_pkg::ST_RUN);
      restart_zero_o   <= (state_q == rtpb_pkg::ST_ZERO);
      match_req_o      <= (state_q == rtpb_pkg::ST_MATCH);
      match_freq_sel_o <= bank_q[rtpb_pkg::IDX_PULLIN][1:0];
      decel_stop_o     <= (state_q == rtpb_pkg::ST_DECEL);
    end
  end

  // Trip and alarm; an under-voltage trip alarms only when enabled
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      trip_o       <= 1'b0;
      alarm_o      <= 1'b0;
      trip_cause_o <= rtpb_pkg::CAUSE_NONE;
    end else if (ce_i) begin
      trip_o       <= (state_q == rtpb_pkg::ST_TRIP);
      alarm_o      <= (state_q == rtpb_pkg::ST_TRIP) &&
                      ((trip_cause_q != rtpb_pkg::CAUSE_UV) ||
                       (bank_q[rtpb_pkg::IDX_ALARM_EN][0] ==
                        rtpb_pkg::ALARM_ON));
      trip_cause_o <= trip_cause_q;
    end
  end

  // Second motor copies take over only while selected
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      thermal_level_o <= rtpb_pkg::REG_RST[rtpb_pkg::IDX_THERM];
      thermal_curve_o <= rtpb_pkg::REG_RST[rtpb_pkg::IDX_CURVE][1:0];
      overload_mode_o <= rtpb_pkg::REG_RST[rtpb_pkg::IDX_OLMODE][1:0];
    end else if (ce_i) begin
      if (motor2_s) begin
        thermal_level_o <= bank_q[rtpb_pkg::IDX_THERM2];
        thermal_curve_o <= bank_q[rtpb_pkg::IDX_CURVE2][1:0];
        overload_mode_o <= bank_q[rtpb_pkg::IDX_OLMODE2][1:0];
      end else begin
        thermal_level_o <= bank_q[rtpb_pkg::IDX_THERM];
        thermal_curve_o <= bank_q[rtpb_pkg::IDX_CURVE][1:0];
        overload_mode_o <= bank_q[rtpb_pkg::IDX_OLMODE][1:0];
      end
    end
  end

endmodule : rtpb_bank

`default_nettype wire

// ==== sim/rtpb_bank_chk.sv ====
/* Port checker for the restart and thermal parameter bank.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none

module rtpb_bank_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        uv_pin_i,
  input wire logic        match_done_i,
  input wire logic        stop_done_i,
  input wire logic        run_enable_o,
  input wire logic        restart_zero_o,
  input wire logic        match_req_o,
  input wire logic        decel_stop_o,
  input wire logic        trip_o,
  input wire logic        alarm_o,
  input wire logic [1:0]  trip_cause_o,
  input wire logic [15:0] thermal_level_o,
  input wire logic [1:0]  thermal_curve_o,
  input wire logic [1:0]  overload_mode_o
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_rdata_idle: assert property (
    ce_i && !rd_i |=> rdata_o == 16'h0000) else $error("read data held");
  a_restart_pulse: assert property (
    restart_zero_o && ce_i |=> !restart_zero_o && run_enable_o)
    else $error("bad zero pulse");
  a_fault_alarm: assert property (
    $rose(trip_o) && trip_cause_o == rtpb_pkg::CAUSE_FAULT |=> alarm_o)
    else $error("no fault alarm");
  a_trip_no_run: assert property (
    trip_o |-> !run_enable_o) else $error("run in trip");
  a_uv_stops_run: assert property (
    run_enable_o && !uv_pin_i ##1 uv_pin_i [*6] |-> !run_enable_o)
    else $error("ran in dip");
  a_match_done: assert property (
    match_req_o && match_done_i |=> match_req_o ##1 !match_req_o)
    else $error("match held");
  a_stop_trips: assert property (
    decel_stop_o && stop_done_i |=> decel_stop_o ##1 (trip_o && !decel_stop_o))
    else $error("no trip after stop");
  a_level_range: assert property (
    thermal_level_o >= 16'h07D0 && thermal_level_o <= 16'h2710)
    else $error("bad level");
  a_curve_code: assert property (
    thermal_curve_o != 2'h3) else $error("bad curve code");
  a_overload_code: assert property (
    overload_mode_o != 2'h3) else $error("bad overload code");
endmodule : rtpb_bank_chk

bind rtpb_bank rtpb_bank_chk u_rtpb_bank_chk (.*);

`default_nettype wire

// ==== sim/rtpb_drive_model.sv ====
/* Drive core model answering the match and stop handshakes.
   Assumes the bank's clock; delay_i sets how slowly it answers. */
`timescale 1ns/1ps
`default_nettype none

module rtpb_drive_model (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] delay_i,
  input  wire logic       match_req_i,
  input  wire logic       decel_stop_i,
  output logic            match_done_o,
  output logic            stop_done_o
);
  logic [7:0] m_cnt_q;
  logic [7:0] s_cnt_q;

  // Age of each request; saturates so a long request answers once
  always_ff @(posedge core_clk_i) begin
    m_cnt_q <= (rst_i || !match_req_i) ? 8'h00
             : m_cnt_q + {7'h00, m_cnt_q != 8'hFF};
    s_cnt_q <= (rst_i || !decel_stop_i) ? 8'h00
             : s_cnt_q + {7'h00, s_cnt_q != 8'hFF};
  end

  // One done pulse per request, at the set delay
  always_ff @(posedge core_clk_i) begin
    match_done_o <= !rst_i && match_req_i && m_cnt_q == delay_i;
    stop_done_o  <= !rst_i && decel_stop_i && s_cnt_q == delay_i;
  end
endmodule : rtpb_drive_model

`default_nettype wire

// ==== sim/tb_restart_thermal_param_bank.sv ====
/* Self-checking bench for the parameter bank.
   Assumes a shortened tenth-second count. */
`timescale 1ns/1ps
`default_nettype none

module tb_restart_thermal_param_bank;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        uv_pin_i = 1'b0;
  logic        fault_pin_i = 1'b0;
  logic        motor2_pin_i = 1'b0;
  logic [7:0]  dly = 8'h00;
  logic        match_done_i, stop_done_i, run_enable_o, restart_zero_o;
  logic        match_req_o, decel_stop_o, trip_o, alarm_o;
  logic [1:0]  match_freq_sel_o, trip_cause_o;
  logic [1:0]  thermal_curve_o, overload_mode_o;
  logic [15:0] rdata_o, thermal_level_o, v;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n;

  rtpb_bank #(.TENTH_CYCLES(4)) u_rtpb_bank (.*);

  rtpb_drive_model u_rtpb_drive_model (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .delay_i(dly),
    .match_req_i(match_req_o), .decel_stop_i(decel_stop_o),
    .match_done_o(match_done_i), .stop_done_o(stop_done_i));

  // Clock; ceiling well above the test length
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data are taken in the one cycle they stand
  task rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  task automatic wait_hi(ref logic s, input int lim);
    for (n = 0; n < lim && s !== 1'b1; n++) begin
      @(posedge core_clk_i);
      #1;
    end
  endtask : wait_hi

  task pulse_fault;
    @(posedge core_clk_i);
    fault_pin_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    fault_pin_i <= 1'b0;
  endtask : pulse_fault

  task clear_trip;
    @(posedge core_clk_i);
    uv_pin_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    wr(16'h1600, 16'h0001);
    repeat (2) @(posedge core_clk_i);
    #1 chk("trip cleared", 16'(trip_o), 16'h0000);
  endtask : clear_trip

  task t_reset_vals;
    for (int i = 0; i < 12; i++) begin
      rd(rtpb_pkg::REG_OFS[i], v);
      chk("reset value", v, rtpb_pkg::REG_RST[i]);
    end
    rd(16'h10AA, v);
    chk("unmapped read", v, 16'h0000);
  endtask : t_reset_vals

  // Both range ends accepted, one past the top refused
  task t_rw;
    for (int i = 0; i < 12; i++) begin
      wr(rtpb_pkg::REG_OFS[i], rtpb_pkg::REG_MAX[i]);
      rd(rtpb_pkg::REG_OFS[i], v);
      chk("top value", v, rtpb_pkg::REG_MAX[i]);
      wr(rtpb_pkg::REG_OFS[i], rtpb_pkg::REG_MIN[i]);
      wr(rtpb_pkg::REG_OFS[i], rtpb_pkg::REG_MAX[i] + 16'h0001);
      rd(rtpb_pkg::REG_OFS[i], v);
      chk("kept value", v, rtpb_pkg::REG_MIN[i]);
    end
    rd(16'h1600, v);
    chk("refused flag", 16'(v[8]), 16'h0001);
    wr(16'h1600, 16'h0100);
    ce_i <= 1'b0;
    wr(rtpb_pkg::REG_OFS[1], 16'h0010);
    ce_i <= 1'b1;
    rd(rtpb_pkg::REG_OFS[1], v);
    chk("frozen write", v, 16'h0003);
  endtask : t_rw

  task t_motor;
    int e;
    wr(rtpb_pkg::REG_OFS[5], 16'h1388);
    for (int c = 0; c < 3; c++) begin
      wr(rtpb_pkg::REG_OFS[6], 16'(c));
      wr(rtpb_pkg::REG_OFS[7], 16'(c));
      wr(rtpb_pkg::REG_OFS[10], 16'(2 - c));
      wr(rtpb_pkg::REG_OFS[11], 16'(2 - c));
      for (int m = 0; m < 2; m++) begin
        @(posedge core_clk_i);
        motor2_pin_i <= m[0];
        repeat (6) @(posedge core_clk_i);
        #1 e = m ? 2 - c : c;
        chk("curve", 16'(thermal_curve_o), 16'(e));
        chk("overload", 16'(overload_mode_o), 16'(e));
        chk("level", thermal_level_o, m ? 16'h07D0 : 16'h1388);
      end
    end
  endtask : t_motor

  // Short dip restarts after the wait; long dip trips
  task t_uv;
    wr(rtpb_pkg::REG_OFS[0], 16'h0001);
    @(posedge core_clk_i);
    uv_pin_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    uv_pin_i <= 1'b0;
    #1 chk("run in dip", 16'(run_enable_o), 16'h0000);
    wait_hi(restart_zero_o, 60);
    chk("retry wait", 16'(n >= 10 && n <= 30), 16'h0001);
    wait_hi(run_enable_o, 4);
    chk("run again", 16'(run_enable_o), 16'h0001);
    for (int a = 0; a < 2; a++) begin
      wr(rtpb_pkg::REG_OFS[3], 16'(a));
      @(posedge core_clk_i);
      uv_pin_i <= 1'b1;
      wait_hi(trip_o, 60);
      chk("dip trip time", 16'(n >= 12 && n <= 30), 16'h0001);
      chk("dip cause", 16'(trip_cause_o), 16'(rtpb_pkg::CAUSE_UV));
      repeat (2) @(posedge core_clk_i);
      #1 chk("dip alarm", 16'(alarm_o), 16'(a));
      clear_trip();
    end
  endtask : t_uv

  task t_fault;
    wr(rtpb_pkg::REG_OFS[0], 16'h0000);
    pulse_fault();
    wait_hi(trip_o, 20);
    chk("fault cause", 16'(trip_cause_o), 16'(rtpb_pkg::CAUSE_FAULT));
    clear_trip();
  endtask : t_fault

  // Drive core answers promptly, then more slowly
  task t_match;
    for (int p = 0; p < 3; p++) begin
      wr(rtpb_pkg::REG_OFS[8], 16'(p));
      wr(rtpb_pkg::REG_OFS[0], 16'h0002);
      dly <= 8'(p * 6);
      pulse_fault();
      wait_hi(match_req_o, 80);
      chk("pull-in code", 16'(match_freq_sel_o), 16'(p));
      wait_hi(run_enable_o, 40);
      chk("match resume", 16'(run_enable_o), 16'h0001);
    end
    wr(rtpb_pkg::REG_OFS[0], 16'h0003);
    pulse_fault();
    wait_hi(decel_stop_o, 80);
    chk("decel", 16'(decel_stop_o), 16'h0001);
    wait_hi(trip_o, 40);
    chk("stop cause", 16'(trip_cause_o), 16'(rtpb_pkg::CAUSE_FAULT));
    clear_trip();
  endtask : t_match

  // Reset in mid-run, then limited and unlimited restart counts
  task t_limit;
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(rtpb_pkg::REG_OFS[0], v);
    chk("method reset", v, 16'h0000);
    wr(rtpb_pkg::REG_OFS[0], 16'h0001);
    for (int s = 0; s < 2; s++) begin
      wr(rtpb_pkg::REG_OFS[4], 16'(s));
      for (int k = 0; k < 17; k++) begin
        pulse_fault();
        if (s == 0 && k == 16) begin
          wait_hi(trip_o, 80);
          chk("limit", 16'(trip_cause_o), 16'(rtpb_pkg::CAUSE_LIMIT));
          rd(16'h1600, v);
          chk("restart count", 16'(v[7:3]), 16'h0010);
          clear_trip();
        end else begin
          wait_hi(restart_zero_o, 80);
          chk("restart", 16'(restart_zero_o), 16'h0001);
          wait_hi(run_enable_o, 4);
        end
      end
    end
  endtask : t_limit

  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset_vals();
    t_rw();
    t_motor();
    t_uv();
    t_fault();
    t_match();
    t_limit();
    report_and_stop();
  end
endmodule : tb_restart_thermal_param_bank

`default_nettype wire
